// ==== core/lpmc_pkg.sv ====
package lpmc_pkg;

    // Clock rate and timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_NS = 50;
    localparam int unsigned BACKUP_WAKE_NS = 500_000;
    localparam int unsigned WAIT_WAKE_NS = 10_000;
    localparam int unsigned REG_START_NS = 400_000;
    // Longest times round down, least times round up
    localparam int unsigned BACKUP_WAKE_CYC = BACKUP_WAKE_NS / CLK_NS;
    localparam int unsigned WAIT_WAKE_CYC = WAIT_WAKE_NS / CLK_NS;
    localparam int unsigned REG_START_CYC = (REG_START_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RC_START_CYC = 16;
    localparam int unsigned CORE_RST_CYC = 8;

    localparam int unsigned NWAKE = 16;
    localparam int unsigned DEB_W = 16;
    localparam int unsigned CNT_W = 16;

    // Main clock source codes
    localparam logic [1:0] CLK_SRC_RC = 2'h0;
    localparam logic [1:0] CLK_SRC_XTAL = 2'h1;
    localparam logic [1:0] CLK_SRC_PLL = 2'h2;

    typedef enum logic [3:0] {
        LPMC_ACTIVE = 4'h0,
        LPMC_SLEEP = 4'h1,
        LPMC_WAIT = 4'h2,
        LPMC_BACKUP = 4'h3,
        LPMC_REG_UP = 4'h4,
        LPMC_CORE_RST = 4'h5,
        LPMC_RC_UP = 4'h6
    } lpmc_state_t;

endpackage

// ==== core/lpmc_wake_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface lpmc_wake_if;
    logic [15:0] wake_en;
    logic [15:0] deb_len;
    logic force_wake_en;
    logic backup_arm;
    logic backup_event;
    logic [15:0] fast_event;
    modport filt (input wake_en, deb_len, force_wake_en, backup_arm,
                  output backup_event, fast_event);
    modport ctl (output wake_en, deb_len, force_wake_en, backup_arm,
                 input backup_event, fast_event);
endinterface
`default_nettype wire

// ==== core/lpmc_sync3.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpmc_sync3 import lpmc_pkg::*; #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Pins
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } lpmc_sync_t;
    lpmc_sync_t st_r, st_nxt;

    // Change counts once second and third stages agree
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < W; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.lvl[i] = st_r.s3[i];
            end
        end
    end

    // Pins idle high (pull-ups)
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.lvl;
endmodule
`default_nettype wire

// ==== core/lpmc_wake_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpmc_wake_filter import lpmc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Synchronised pin levels
    input wire logic fw_lvl,
    input wire logic [NWAKE-1:0] wk_lvl,
    // Control side
    lpmc_wake_if.filt wif
);
    typedef struct packed {
        logic [NWAKE-1:0] stable;
        logic [NWAKE-1:0] fast_lvl;
        logic [NWAKE*DEB_W-1:0] wcnt;
        logic [DEB_W-1:0] fcnt;
        logic fire;
    } lpmc_filt_t;
    lpmc_filt_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.fire = 1'b0;
        // Force-wake: low level held for the debounce length
        if (!fw_lvl && wif.force_wake_en && wif.backup_arm) begin
            if (st_r.fcnt >= wif.deb_len) begin
                st_nxt.fire = 1'b1;
            end else begin
                st_nxt.fcnt = st_r.fcnt + 1'b1;
            end
        end else begin
            st_nxt.fcnt = '0;
        end
        // Each input: a new level must stand the debounce length
        for (int i = 0; i < NWAKE; i++) begin
            if (wk_lvl[i] == st_r.stable[i]) begin
                st_nxt.wcnt[i*DEB_W +: DEB_W] = '0;
            end else if (st_r.wcnt[i*DEB_W +: DEB_W] >= wif.deb_len) begin
                st_nxt.stable[i] = wk_lvl[i];
                st_nxt.wcnt[i*DEB_W +: DEB_W] = '0;
                if (wif.wake_en[i] && wif.backup_arm) begin
                    st_nxt.fire = 1'b1;
                end
            end else begin
                st_nxt.wcnt[i*DEB_W +: DEB_W] = st_r.wcnt[i*DEB_W +: DEB_W] + 1'b1;
            end
        end
        // Fast start-up uses the raw low level, no debounce
        st_nxt.fast_lvl = ~wk_lvl & wif.wake_en;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
            st_r.stable <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wif.backup_event = st_r.fire;
    assign wif.fast_event = st_r.fast_lvl;

    a_fw_debounce: assert property (@(posedge clk) disable iff (!nrst)
        (st_r.fcnt != '0 && $past(fw_lvl)) |-> 1'b0)
        else $error("force-wake counter ran while pin was high");
endmodule
`default_nettype wire

// ==== core/lpmc_top.sv ====
// What this block does
// - Event wait with deep sleep set enters backup, regulator switched off.
// - Backup domain logic stays powered; only core supply is cut.
// - Enabled force-wake pin held low past debounce ends backup.
// - Each enabled wake input ends backup on a debounced level change.
// - Enabled supply monitor, clock and timer alarms also end backup.
// - Backup wake-up reaches first fetch within 0.5 ms.
// - Event wait with low-power bit set, deep sleep clear, enters wait.
// - Wait stops core, peripheral and memory clocks, power kept.
// - Wait ends on fast wake input, clock alarm, timer alarm or USB.
// - Wait exit under 10 us; core reclocked, not reset.
// - Either wait with low-power bit and deep sleep clear enters sleep.
// - Sleep stops only the core clock.
// - Interrupt wait ends on interrupt; event wait on any event.
// - Active core clock from RC, crystal or PLL, with peripheral gating.
// - Regulator managed here; shut down output pulled to ground.
// - After regulator restart wait 400 us before releasing core.
// - Backup wake event automatically restarts core supply.
// - Fast start-up restarts RC, switches main clock, re-clocks core.
`timescale 1ns/1ps
`default_nettype none
module lpmc_top import lpmc_pkg::*; #(
    parameter int unsigned REG_START_CYCLES = REG_START_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Core sleep request
    input wire logic core_wfe,
    input wire logic core_wfi,
    input wire logic deep_sleep_bit,
    input wire logic core_irq,
    // Configuration
    input wire logic low_power_select_bit,
    input wire logic [1:0] clk_src_sel,
    input wire logic [31:0] periph_clk_en,
    input wire logic [15:0] debounce_len,
    input wire logic force_wake_en,
    input wire logic [NWAKE-1:0] wake_inputs_en,
    input wire logic sm_wake_en,
    input wire logic rtc_wake_en,
    input wire logic rtt_wake_en,
    input wire logic fast_rtc_en,
    input wire logic fast_rtt_en,
    input wire logic fast_usb_en,
    // Wake sources
    input wire logic force_wake_pin,
    input wire logic [NWAKE-1:0] wake_inputs,
    input wire logic supply_monitor_alarm,
    input wire logic rtc_alarm,
    input wire logic real_time_timer_alarm,
    input wire logic usb_wake,
    // Oscillator status
    input wire logic fast_rc_ready,
    // Clock and power controls
    output logic core_clk_en,
    output logic [31:0] periph_clk_gate,
    output logic mem_clk_en,
    output logic [1:0] main_clk_src,
    output logic fast_rc_enable_bit,
    output logic regulator_shutdown_ctl,
    output logic regulator_pulldown,
    output logic core_power_on,
    output logic core_rst_n,
    output logic backup_domain_on,
    // Status
    output logic [3:0] mode_state,
    output logic wake_done
);
    // -------------------------------------------------------------
    // Synchronisers and wake filter
    // -------------------------------------------------------------
    logic [NWAKE:0] pin_lvl;
    logic [3:0] alarm_lvl;
    lpmc_wake_if wif ();

    lpmc_sync3 #(.W(NWAKE + 1)) u_sync_pins (
        .clk(clk),
        .nrst(nrst),
        .pin({force_wake_pin, wake_inputs}),
        .level(pin_lvl)
    );

    // Alarms and USB wake cross from other domains
    lpmc_sync3 #(.W(4)) u_sync_alarm (
        .clk(clk),
        .nrst(nrst),
        .pin(~{supply_monitor_alarm, rtc_alarm, real_time_timer_alarm, usb_wake}),
        .level(alarm_lvl)
    );

    lpmc_wake_filter u_filt (
        .clk(clk),
        .nrst(nrst),
        .fw_lvl(pin_lvl[NWAKE]),
        .wk_lvl(pin_lvl[NWAKE-1:0]),
        .wif(wif)
    );

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        lpmc_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] wake_cnt;
        logic by_wfe;
        logic wake_from_backup;
        logic [1:0] clk_src;
        logic rc_en;
        logic done;
    } lpmc_ctl_t;
    lpmc_ctl_t st_r, st_nxt;

    logic sm_al, rtc_al, rtt_al, usb_wk;
    logic backup_wake, fast_wake, sleep_wake;

    assign sm_al = ~alarm_lvl[3];
    assign rtc_al = ~alarm_lvl[2];
    assign rtt_al = ~alarm_lvl[1];
    assign usb_wk = ~alarm_lvl[0];

    assign wif.wake_en = wake_inputs_en;
    assign wif.deb_len = debounce_len;
    assign wif.force_wake_en = force_wake_en;
    assign wif.backup_arm = (st_r.st == LPMC_BACKUP);

    // Backup wake sources
    assign backup_wake = wif.backup_event
        || (sm_wake_en && sm_al)
        || (rtc_wake_en && rtc_al)
        || (rtt_wake_en && rtt_al);
    // Fast start-up sources for wait and event sleep
    assign fast_wake = (|wif.fast_event)
        || (fast_rtc_en && rtc_al)
        || (fast_rtt_en && rtt_al)
        || (fast_usb_en && usb_wk);
    // Interrupt wait ends on interrupt only
    assign sleep_wake = st_r.by_wfe ? (core_irq || fast_wake) : core_irq;

    // -------------------------------------------------------------
    // Mode sequencer
    // -------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (st_r.st != LPMC_ACTIVE && st_r.st != LPMC_SLEEP && st_r.st != LPMC_WAIT
            && st_r.st != LPMC_BACKUP) begin
            st_nxt.wake_cnt = st_r.wake_cnt + 1'b1;
        end
        case (st_r.st)
            LPMC_ACTIVE: begin
                st_nxt.clk_src = clk_src_sel;
                st_nxt.rc_en = 1'b1;
                if (core_wfe && deep_sleep_bit) begin
                    st_nxt.st = LPMC_BACKUP;
                end else if (core_wfe && low_power_select_bit) begin
                    st_nxt.st = LPMC_WAIT;
                    st_nxt.rc_en = 1'b0;
                end else if ((core_wfe || core_wfi) && !deep_sleep_bit) begin
                    st_nxt.st = LPMC_SLEEP;
                    st_nxt.by_wfe = core_wfe;
                end
            end
            LPMC_SLEEP: begin
                if (sleep_wake) begin
                    st_nxt.st = LPMC_ACTIVE;
                    st_nxt.done = 1'b1;
                end
            end
            LPMC_WAIT: begin
                if (fast_wake) begin
                    st_nxt.st = LPMC_RC_UP;
                    st_nxt.rc_en = 1'b1;
                    st_nxt.clk_src = CLK_SRC_RC;
                    st_nxt.cnt = '0;
                    st_nxt.wake_cnt = '0;
                    st_nxt.wake_from_backup = 1'b0;
                end
            end
            LPMC_BACKUP: begin
                if (backup_wake) begin
                    st_nxt.st = LPMC_REG_UP;
                    st_nxt.cnt = '0;
                    st_nxt.wake_cnt = '0;
                    st_nxt.wake_from_backup = 1'b1;
                end
            end
            LPMC_REG_UP: begin
                st_nxt.cnt = st_r.cnt + 1'b1;
                if (st_r.cnt >= CNT_W'(REG_START_CYCLES - 1)) begin
                    st_nxt.st = LPMC_RC_UP;
                    st_nxt.rc_en = 1'b1;
                    st_nxt.clk_src = CLK_SRC_RC;
                    st_nxt.cnt = '0;
                end
            end
            LPMC_RC_UP: begin
                st_nxt.cnt = st_r.cnt + 1'b1;
                if (fast_rc_ready || st_r.cnt >= CNT_W'(RC_START_CYC - 1)) begin
                    st_nxt.cnt = '0;
                    if (st_r.wake_from_backup) begin
                        st_nxt.st = LPMC_CORE_RST;
                    end else begin
                        st_nxt.st = LPMC_ACTIVE;
                        st_nxt.done = 1'b1;
                    end
                end
            end
            LPMC_CORE_RST: begin
                st_nxt.cnt = st_r.cnt + 1'b1;
                if (st_r.cnt >= CNT_W'(CORE_RST_CYC - 1)) begin
                    st_nxt.st = LPMC_ACTIVE;
                    st_nxt.done = 1'b1;
                    st_nxt.wake_from_backup = 1'b0;
                end
            end
            default: begin
                st_nxt.st = LPMC_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
            st_r.st <= LPMC_ACTIVE;
            st_r.clk_src <= CLK_SRC_RC;
            st_r.rc_en <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    logic powered;
    assign powered = (st_r.st != LPMC_BACKUP) && (st_r.st != LPMC_REG_UP);

    // Core clock only in active; sleep keeps peripherals clocked
    assign core_clk_en = (st_r.st == LPMC_ACTIVE);
    assign periph_clk_gate = (st_r.st == LPMC_ACTIVE || st_r.st == LPMC_SLEEP)
        ? periph_clk_en : 32'h0000_0000;
    assign mem_clk_en = (st_r.st == LPMC_ACTIVE || st_r.st == LPMC_SLEEP);
    assign main_clk_src = st_r.clk_src;
    assign fast_rc_enable_bit = st_r.rc_en;
    // Low means regulator off, as the pin level convention
    assign regulator_shutdown_ctl = (st_r.st != LPMC_BACKUP);
    assign regulator_pulldown = (st_r.st == LPMC_BACKUP);
    assign core_power_on = powered;
    // Held through RC start too, so a backup wake never lets the core run early
    assign core_rst_n = powered && !st_r.wake_from_backup;
    assign backup_domain_on = 1'b1;
    assign mode_state = st_r.st;
    assign wake_done = st_r.done;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    a_backup_entry: assert property (@(posedge clk) disable iff (!nrst)
        (st_r.st == LPMC_ACTIVE && core_wfe && deep_sleep_bit) |=> !regulator_shutdown_ctl)
        else $error("backup entry did not shut regulator");
    a_wait_entry: assert property (@(posedge clk) disable iff (!nrst)
        (st_r.st == LPMC_ACTIVE && core_wfe && !deep_sleep_bit && low_power_select_bit)
        |=> (st_r.st == LPMC_WAIT && !core_clk_en && !mem_clk_en))
        else $error("wait entry failed");
    a_wait_power: assert property (@(posedge clk) disable iff (!nrst)
        (st_r.st == LPMC_WAIT) |-> (core_power_on && periph_clk_gate == 32'h0000_0000))
        else $error("wait mode power or clocks wrong");
    a_sleep_entry: assert property (@(posedge clk) disable iff (!nrst)
        (st_r.st == LPMC_ACTIVE && core_wfi && !core_wfe && !deep_sleep_bit)
        |=> st_r.st == LPMC_SLEEP)
        else $error("sleep entry failed");
    a_sleep_clocks: assert property (@(posedge clk) disable iff (!nrst)
        (st_r.st == LPMC_SLEEP) |-> (!core_clk_en && periph_clk_gate == periph_clk_en))
        else $error("sleep clock gating wrong");
    a_wfi_irq_only: assert property (@(posedge clk) disable iff (!nrst)
        (st_r.st == LPMC_SLEEP && !st_r.by_wfe && !core_irq) |=> st_r.st == LPMC_SLEEP)
        else $error("interrupt sleep left without interrupt");
    a_wait_wake_time: assert property (@(posedge clk) disable iff (!nrst)
        (st_r.st == LPMC_WAIT && fast_wake) |-> ##[1:40] (core_clk_en && core_rst_n))
        else $error("wait wake-up too slow");
    a_reg_settle: assert property (@(posedge clk) disable iff (!nrst)
        (st_r.st == LPMC_REG_UP) |-> !core_rst_n)
        else $error("core released during regulator start");
    a_backup_time: assert property (@(posedge clk) disable iff (!nrst)
        (st_r.st != LPMC_ACTIVE && st_r.wake_from_backup)
        |-> st_r.wake_cnt < CNT_W'(BACKUP_WAKE_CYC))
        else $error("backup wake-up over budget");
    a_rc_switch: assert property (@(posedge clk) disable iff (!nrst)
        (st_r.st == LPMC_WAIT && fast_wake) |=> (main_clk_src == CLK_SRC_RC && fast_rc_enable_bit))
        else $error("fast start-up did not switch to RC");
endmodule
`default_nettype wire

// ==== verification/lpmc_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpmc_core_model import lpmc_pkg::*; (
    // Clock
    input wire logic clk,
    // Status read back by software
    input wire logic fast_rc_enable_bit,
    // Requests and qualifiers
    output logic core_wfe,
    output logic core_wfi,
    output logic deep_sleep_bit,
    output logic low_power_select_bit,
    output logic [1:0] clk_src_sel,
    output logic core_irq
);
    initial begin
        core_wfe = 1'b0;
        core_wfi = 1'b0;
        deep_sleep_bit = 1'b0;
        low_power_select_bit = 1'b0;
        clk_src_sel = CLK_SRC_RC;
        core_irq = 1'b0;
    end

    // ----------
    // Software sequences
    // ----------
    // Qualifiers settle a cycle before the one-cycle wait pulse
    task automatic request(input logic wfe, wfi, deep, lps);
        @(posedge clk);
        if (lps && !deep) begin
            clk_src_sel <= CLK_SRC_RC;
            @(posedge clk);
        end
        deep_sleep_bit <= deep;
        low_power_select_bit <= lps;
        @(posedge clk);
        core_wfe <= wfe;
        core_wfi <= wfi;
        @(posedge clk);
        core_wfe <= 1'b0;
        core_wfi <= 1'b0;
    endtask

    task automatic select(input logic [1:0] s);
        @(posedge clk);
        clk_src_sel <= s;
    endtask

    // Bounded poll, a stuck enable bit must not hang software
    task automatic poll_rc_off(output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge clk);
            ok = (fast_rc_enable_bit === 1'b0);
        end
    endtask

    task automatic irq_pulse();
        @(posedge clk);
        core_irq <= 1'b1;
        @(posedge clk);
        core_irq <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== verification/tb_lpmc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_lpmc_top;
    import lpmc_pkg::*;
    localparam int REG_N = 20;
    localparam int LIMIT = 20000;
    typedef struct packed {
        logic [3:0] req;
        logic [3:0] st;
        logic [2:0] on;
    } lpmc_row_t;

    logic clk, nrst, core_wfe, core_wfi, deep_sleep_bit, core_irq, low_power_select_bit;
    logic [1:0] clk_src_sel, main_clk_src;
    logic [31:0] periph_clk_en, periph_clk_gate;
    logic [15:0] debounce_len, wake_inputs_en, wake_inputs;
    logic force_wake_en, sm_wake_en, rtc_wake_en, rtt_wake_en, fast_rtc_en, fast_rtt_en;
    logic fast_usb_en, force_wake_pin, supply_monitor_alarm, rtc_alarm;
    logic real_time_timer_alarm, usb_wake, fast_rc_ready, core_clk_en, mem_clk_en;
    logic fast_rc_enable_bit, regulator_shutdown_ctl, regulator_pulldown, core_power_on;
    logic core_rst_n, backup_domain_on, wake_done, rst_q, ok;
    logic [3:0] mode_state;
    int fail_count, checks, cyc, rst_cnt, reg_cnt;
    // Request nibble wfe wfi deep lps; on bits core, memory, regulator
    lpmc_row_t rows [6] = '{{4'h8, LPMC_SLEEP, 3'h3}, {4'h4, LPMC_SLEEP, 3'h3},
        {4'h5, LPMC_SLEEP, 3'h3}, {4'h9, LPMC_WAIT, 3'h1},
        {4'ha, LPMC_BACKUP, 3'h0}, {4'hb, LPMC_BACKUP, 3'h0}};

    lpmc_top #(.REG_START_CYCLES(REG_N)) DUT (.clk, .nrst, .core_wfe, .core_wfi,
        .deep_sleep_bit, .core_irq, .low_power_select_bit, .clk_src_sel, .periph_clk_en,
        .debounce_len, .force_wake_en, .wake_inputs_en, .sm_wake_en, .rtc_wake_en,
        .rtt_wake_en, .fast_rtc_en, .fast_rtt_en, .fast_usb_en, .force_wake_pin,
        .wake_inputs, .supply_monitor_alarm, .rtc_alarm, .real_time_timer_alarm,
        .usb_wake, .fast_rc_ready, .core_clk_en, .periph_clk_gate, .mem_clk_en,
        .main_clk_src, .fast_rc_enable_bit, .regulator_shutdown_ctl, .regulator_pulldown,
        .core_power_on, .core_rst_n, .backup_domain_on, .mode_state, .wake_done);

    lpmc_core_model core_m (.clk, .fast_rc_enable_bit, .core_wfe, .core_wfi,
        .deep_sleep_bit, .low_power_select_bit, .clk_src_sel, .core_irq);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----------
    // Monitor and timeout
    // ----------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rst_q <= core_rst_n;
        if (core_rst_n === 1'b1 && rst_q === 1'b0) rst_cnt <= rst_cnt + 1;
        if (mode_state === LPMC_REG_UP) reg_cnt <= reg_cnt + 1;
        if (cyc == LIMIT) begin
            fail_count++;
            report_and_stop();
        end
    end

    // ----------
    // Shared tasks
    // ----------
    task automatic chk(input string what, input logic [31:0] exp, got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic enter(input logic [3:0] r);
        core_m.request(r[3], r[2], r[1], r[0]);
        @(negedge clk);
        rst_cnt = 0;
        reg_cnt = 0;
    endtask

    // Counts from the wake stimulus; releases of core reset tell reset from reclock
    task automatic woke(input int lim, input logic rst_exp);
        int n;
        n = 0;
        while (wake_done !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk("wake time", 1'b1, n < lim);
        chk("active", LPMC_ACTIVE, mode_state);
        chk("core clock on", 1'b1, core_clk_en);
        // Monitor counts a reset release one edge after it shows
        @(negedge clk);
        chk("core reset releases", rst_exp, rst_cnt);
        chk("regulator hold", rst_exp ? REG_N : 0, reg_cnt);
        @(posedge clk);
        force_wake_pin <= 1'b1;
        wake_inputs <= 16'hffff;
        {supply_monitor_alarm, rtc_alarm, real_time_timer_alarm, usb_wake} <= 4'h0;
        fast_rc_ready <= 1'b1;
        repeat (12) @(posedge clk);
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------
    // Main sequence
    // ----------
    initial begin
        {nrst, supply_monitor_alarm, rtc_alarm, real_time_timer_alarm, usb_wake} = 5'h0;
        {force_wake_en, sm_wake_en, rtc_wake_en, rtt_wake_en} = 4'hf;
        {fast_rtc_en, fast_rtt_en, fast_usb_en} = 3'h6;
        {force_wake_pin, fast_rc_ready} = 2'h3;
        periph_clk_en = 32'h0000_00ff;
        debounce_len = 16'h0004;
        wake_inputs_en = 16'h0028;
        wake_inputs = 16'hffff;
        {fail_count, checks, cyc, rst_cnt, reg_cnt} = '0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
        foreach (rows[i]) begin
            enter(rows[i].req);
            chk("mode", rows[i].st, mode_state);
            chk("core clock", rows[i].on[2], core_clk_en);
            chk("regulator", rows[i].on[0], regulator_shutdown_ctl);
            if (rows[i].st == LPMC_SLEEP) begin
                chk("memory clock", 1'b1, mem_clk_en);
                chk("periph gate", periph_clk_en, periph_clk_gate);
                @(posedge clk);
                wake_inputs[3] <= 1'b0;
                if (rows[i].req[2]) begin
                    repeat (12) @(negedge clk);
                    chk("wfi sleep kept", LPMC_SLEEP, mode_state);
                    core_m.irq_pulse();
                end
                woke(40, 1'b0);
            end else if (rows[i].st == LPMC_WAIT) begin
                chk("memory clock", 1'b0, mem_clk_en);
                chk("periph gate", 32'h0, periph_clk_gate);
                @(posedge clk);
                fast_rc_ready <= 1'b0;
                core_m.poll_rc_off(ok);
                chk("rc off in wait", 1'b1, ok);
                // Ready stays low so the RC start-up timeout carries the exit
                @(posedge clk);
                wake_inputs[3] <= 1'b0;
                woke(WAIT_WAKE_CYC, 1'b0);
                chk("clock source", CLK_SRC_RC, main_clk_src);
                chk("rc enable", 1'b1, fast_rc_enable_bit);
            end else begin
                chk("pulldown", 1'b1, regulator_pulldown);
                chk("core power", 1'b0, core_power_on);
                chk("backup domain", 1'b1, backup_domain_on);
                @(posedge clk);
                force_wake_pin <= 1'b0;
                woke(BACKUP_WAKE_CYC, 1'b1);
            end
        end
        // Source selection and gating in active
        for (int s = 1; s < 3; s++) begin
            core_m.select(s[1:0]);
            periph_clk_en <= 32'h0000_0f0f << s;
            repeat (3) @(negedge clk);
            chk("main source", s, main_clk_src);
            chk("active gate", 32'h0000_0f0f << s, periph_clk_gate);
        end
        // Requests outside active are ignored
        enter(4'h4);
        core_m.request(1'b1, 1'b0, 1'b1, 1'b0);
        @(negedge clk);
        chk("refused request", LPMC_SLEEP, mode_state);
        core_m.irq_pulse();
        woke(8, 1'b0);
        // Wait exits by clock, timer and, once enabled, usb
        for (int i = 0; i < 3; i++) begin
            enter(4'h9);
            @(posedge clk);
            {usb_wake, real_time_timer_alarm, rtc_alarm} <= 3'h1 << i;
            if (i == 2) begin
                repeat (12) @(negedge clk);
                chk("usb masked", LPMC_WAIT, mode_state);
                @(posedge clk);
                fast_usb_en <= 1'b1;
            end
            woke(WAIT_WAKE_CYC, 1'b0);
        end
        // Backup exits by wake input edge and alarms; disabled force pin ignored
        @(posedge clk);
        force_wake_en <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            enter(4'ha);
            @(posedge clk);
            if (i == 0) begin
                force_wake_pin <= 1'b0;
                repeat (20) @(negedge clk);
                chk("force pin masked", LPMC_BACKUP, mode_state);
                @(posedge clk);
            end
            {real_time_timer_alarm, rtc_alarm, supply_monitor_alarm, wake_inputs[5]}
                <= (4'h1 << i) ^ 4'h1;
            woke(BACKUP_WAKE_CYC, 1'b1);
        end
        // Reset in mid backup restores active defaults
        enter(4'ha);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(negedge clk);
        chk("reset mode", LPMC_ACTIVE, mode_state);
        chk("reset regulator", 1'b1, regulator_shutdown_ctl);
        chk("reset core clock", 1'b1, core_clk_en);
        chk("reset source", CLK_SRC_RC, main_clk_src);
        chk("reset rc enable", 1'b1, fast_rc_enable_bit);
        @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(negedge clk);
        chk("mode after reset", LPMC_ACTIVE, mode_state);
        chk("core reset after reset", 1'b1, core_rst_n);
        report_and_stop();
    end
endmodule
`default_nettype wire
